// ### hw/lpm_ctrl.sv
// low-power mode controller: wait and stop sequencing, clock gates, unit controls
`timescale 1ns/100ps
module lpm_ctrl #(
  parameter int XTAL_DIV = 4,
  parameter int RECOV_FULL = lpm_pkg::RECOV_FULL,
  parameter int RECOV_SHORT = lpm_pkg::RECOV_SHORT
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [7:0] o_rdata,
  // processor core
  input wire logic i_wait_exec,
  input wire logic i_stop_exec,
  input wire logic i_ext_pin_irq_mask_load,
  input wire logic i_ext_pin_irq_mask_val,
  output logic o_ext_pin_irq_mask,
  // wake and reset sources
  input wire lpm_pkg::lpm_wake_t i_wake,
  input wire logic i_ext_pin_irq_mask,
  input wire logic i_keypad_irq_mask,
  input wire logic i_ext_rst,
  input wire logic i_lvi_trip,
  input wire logic i_wdog_timeout,
  // outputs to clocks and units
  output lpm_pkg::lpm_clk_t o_clk,
  output lpm_pkg::lpm_unit_t o_unit,
  output logic o_reset_req,
  output lpm_pkg::lpm_state_t o_state
);
  lpm_pkg::lpm_state_t state_q, state_d;
  logic [7:0] cfg_one_q, cfg_two_q, pll_ctl_q;
  logic exit_rst_q, exit_irq_q;
  logic [7:0] div_q;
  logic tick_q;
  logic rec_done;
  logic rec_start;
  logic stop_ok, keep_alive, lvi_rst, wdog_rst, rst_evt;
  logic wake_wait, wake_stop;
  lpm_pkg::lpm_clk_t clk_d;
  lpm_pkg::lpm_unit_t unit_d;

  // bit read helper for config fields
  function automatic logic fld(input logic [7:0] r, input int b);
    fld = r[b];
  endfunction : fld

  // crystal-clock tick divider
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (div_q == 8'(XTAL_DIV - 1)) begin
      div_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  // configuration decode
  assign keep_alive = fld(cfg_two_q, lpm_pkg::KEEP_ALIVE_BIT);
  assign stop_ok = fld(cfg_one_q, lpm_pkg::STOP_EN_BIT);
  assign lvi_rst = i_lvi_trip && fld(cfg_one_q, lpm_pkg::LVI_PWR_BIT)
    && fld(cfg_one_q, lpm_pkg::LVI_RST_BIT)
    && (state_q != lpm_pkg::ST_STOP || fld(cfg_one_q, lpm_pkg::LVI_STOP_BIT));
  assign wdog_rst = i_wdog_timeout && fld(cfg_one_q, lpm_pkg::WDOG_EN_BIT)
    && (state_q == lpm_pkg::ST_RUN || state_q == lpm_pkg::ST_WAIT);
  assign rst_evt = i_ext_rst || lvi_rst || wdog_rst;

  // wake conditions per mode
  assign wake_wait = (i_wake.ext_irq && !i_ext_pin_irq_mask)
    || (i_wake.key_irq && !i_keypad_irq_mask)
    || i_wake.adc_irq || i_wake.sci_irq || i_wake.spi_irq
    || i_wake.tim_irq || i_wake.tbm_irq || i_wake.cgm_irq;
  assign wake_stop = (i_wake.ext_irq && !i_ext_pin_irq_mask)
    || (i_wake.key_irq && !i_keypad_irq_mask)
    || (i_wake.tbm_irq && keep_alive);

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      lpm_pkg::ST_RUN: begin
        if (rst_evt) begin
          state_d = lpm_pkg::ST_RUN;
        end else if (i_stop_exec && stop_ok) begin
          state_d = lpm_pkg::ST_STOP;
        end else if (i_wait_exec) begin
          state_d = lpm_pkg::ST_WAIT;
        end
      end
      lpm_pkg::ST_WAIT: begin
        if (rst_evt || wake_wait) begin
          state_d = lpm_pkg::ST_RUN;
        end
      end
      lpm_pkg::ST_STOP: begin
        if (rst_evt || wake_stop) begin
          state_d = lpm_pkg::ST_RECOVER;
        end
      end
      lpm_pkg::ST_RECOVER: begin
        if (rec_done) begin
          state_d = lpm_pkg::ST_RUN;
        end
      end
      default: state_d = lpm_pkg::ST_RUN;
    endcase
  end

  assign rec_start = state_q == lpm_pkg::ST_STOP && state_d == lpm_pkg::ST_RECOVER;

  // state register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= lpm_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // stop recovery counter
  lpm_recovery #(
    .FULL(RECOV_FULL),
    .SHORT(RECOV_SHORT),
    .W(lpm_pkg::RECOV_W)
  ) u_recovery (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(rec_start),
    .i_short(fld(cfg_one_q, lpm_pkg::SHORT_REC_BIT)),
    .i_tick(tick_q),
    .o_done(rec_done)
  );

  // clock gates for the next state
  always_comb begin
    clk_d = '0;
    case (state_d)
      lpm_pkg::ST_RUN, lpm_pkg::ST_WAIT: begin
        clk_d.cpu = state_d == lpm_pkg::ST_RUN;
        clk_d.bus = 1'b1;
        clk_d.osc = 1'b1;
        clk_d.pll = fld(pll_ctl_q, lpm_pkg::PLL_PWR_BIT);
        clk_d.pll_sel = fld(pll_ctl_q, lpm_pkg::BASE_SEL_BIT)
          && fld(pll_ctl_q, lpm_pkg::PLL_PWR_BIT);
        clk_d.xtal_out = 1'b1;
        clk_d.gen_out = 1'b1;
        clk_d.gen_irq = 1'b1;
        clk_d.wdog = 1'b1;
      end
      lpm_pkg::ST_STOP: begin
        clk_d.bus = keep_alive;
        clk_d.osc = keep_alive;
        clk_d.xtal_out = keep_alive;
        clk_d.gen_out = keep_alive;
        clk_d.gen_irq = keep_alive;
      end
      lpm_pkg::ST_RECOVER: begin
        clk_d.osc = 1'b1;
        clk_d.xtal_out = 1'b1;
      end
      default: clk_d = '0;
    endcase
  end

  // unit controls for the next state
  always_comb begin
    unit_d = '0;
    unit_d.brk_act = state_d == lpm_pkg::ST_RUN || state_d == lpm_pkg::ST_WAIT;
    unit_d.adc_act = unit_d.brk_act;
    unit_d.sci_act = unit_d.brk_act;
    unit_d.spi_act = unit_d.brk_act;
    unit_d.tim_act = unit_d.brk_act;
    unit_d.tbm_act = unit_d.brk_act
      || ((state_d == lpm_pkg::ST_STOP) && keep_alive);
    unit_d.tbm_access = state_d == lpm_pkg::ST_RUN;
    unit_d.lvi_act = fld(cfg_one_q, lpm_pkg::LVI_PWR_BIT)
      && (state_d != lpm_pkg::ST_STOP || fld(cfg_one_q, lpm_pkg::LVI_STOP_BIT));
    unit_d.adc_abort = state_q == lpm_pkg::ST_RUN && state_d == lpm_pkg::ST_STOP;
    unit_d.sci_frame_bad = unit_d.adc_abort;
    unit_d.sim_clr = unit_d.adc_abort;
    unit_d.spi_reset = rst_evt && state_q != lpm_pkg::ST_RUN;
  end

  // registered outputs
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_clk <= '0;
      o_unit <= '0;
      o_state <= lpm_pkg::ST_RUN;
      o_reset_req <= 1'b0;
    end else begin
      o_clk <= clk_d;
      o_unit <= unit_d;
      o_state <= state_d;
      o_reset_req <= lvi_rst || wdog_rst;
    end
  end

  // interrupt mask flag and exit cause
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ext_pin_irq_mask <= 1'b1;
      exit_rst_q <= 1'b0;
      exit_irq_q <= 1'b0;
    end else if (rst_evt) begin
      o_ext_pin_irq_mask <= 1'b1;
      exit_rst_q <= state_q != lpm_pkg::ST_RUN;
      exit_irq_q <= 1'b0;
    end else if (state_q == lpm_pkg::ST_RUN && state_d != lpm_pkg::ST_RUN) begin
      o_ext_pin_irq_mask <= 1'b0;
    end else if (state_q != lpm_pkg::ST_RUN && state_d != state_q) begin
      exit_irq_q <= 1'b1;
      exit_rst_q <= 1'b0;
    end else if (i_ext_pin_irq_mask_load && state_q == lpm_pkg::ST_RUN) begin
      o_ext_pin_irq_mask <= i_ext_pin_irq_mask_val;
    end
  end

  // register writes
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_one_q <= lpm_pkg::CFG_ONE_RST;
      cfg_two_q <= lpm_pkg::CFG_TWO_RST;
      pll_ctl_q <= lpm_pkg::PLL_CTL_RST;
    end else if (i_we) begin
      case (i_addr)
        lpm_pkg::CFG_ONE_OFS: cfg_one_q <= {2'b00, i_wdata[5:0]};
        lpm_pkg::CFG_TWO_OFS: cfg_two_q <= {7'h00, i_wdata[0]};
        lpm_pkg::PLL_CTL_OFS: pll_ctl_q <= {6'h00, i_wdata[1:0]};
        default: ;
      endcase
    end
  end

  // register reads, data in the next cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_re) begin
      case (i_addr)
        lpm_pkg::CFG_ONE_OFS: o_rdata <= cfg_one_q;
        lpm_pkg::CFG_TWO_OFS: o_rdata <= cfg_two_q;
        lpm_pkg::PLL_CTL_OFS: o_rdata <= pll_ctl_q;
        lpm_pkg::STATUS_OFS: o_rdata <= {3'h0, exit_irq_q, exit_rst_q, o_ext_pin_irq_mask, state_q};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  wait_gates_a: assert property (o_state == lpm_pkg::ST_WAIT |-> !o_clk.cpu && o_clk.bus)
    else $error("wait gates wrong");
  stop_bus_a: assert property (o_state == lpm_pkg::ST_STOP && !keep_alive |-> !o_clk.bus
    && !o_clk.osc && !o_clk.gen_out && !o_clk.xtal_out)
    else $error("stop gates wrong");
  stop_pll_a: assert property (o_state == lpm_pkg::ST_STOP |-> !o_clk.pll && !o_clk.cpu
    && o_clk.osc == keep_alive)
    else $error("stop pll wrong");
  stop_disabled_a: assert property (state_q == lpm_pkg::ST_RUN && i_stop_exec && !stop_ok
    && !i_wait_exec |=> state_q == lpm_pkg::ST_RUN)
    else $error("stop taken while disabled");
  wait_mask_a: assert property (state_q == lpm_pkg::ST_RUN && i_wait_exec && !rst_evt
    && !(i_stop_exec && stop_ok) |=> !o_ext_pin_irq_mask && state_q == lpm_pkg::ST_WAIT)
    else $error("wait kept mask");
  reset_mask_a: assert property (rst_evt |=> o_ext_pin_irq_mask)
    else $error("reset exit left mask clear");
  recover_cpu_a: assert property (o_state == lpm_pkg::ST_RECOVER |-> !o_clk.cpu)
    else $error("cpu clock in recovery");
  recover_min_a: assert property ($rose(state_q == lpm_pkg::ST_RECOVER)
    |-> (state_q == lpm_pkg::ST_RECOVER)[*8])
    else $error("recovery too short");
  stop_units_a: assert property (o_state == lpm_pkg::ST_STOP |-> !o_clk.wdog
    && !o_unit.adc_act && !o_unit.tim_act && !o_unit.tbm_access)
    else $error("unit active in stop");
  stop_entry_a: assert property (state_q == lpm_pkg::ST_RUN && state_d == lpm_pkg::ST_STOP
    |=> o_unit.adc_abort && o_unit.sim_clr ##1 !o_unit.adc_abort)
    else $error("stop entry pulses wrong");
  tbm_access_a: assert property (o_state == lpm_pkg::ST_WAIT |-> !o_unit.tbm_access
    && o_unit.tbm_act)
    else $error("timebase access in wait");
  wake_wait_a: assert property (state_q == lpm_pkg::ST_WAIT && i_wake.ext_irq
    && !i_ext_pin_irq_mask |=> state_q == lpm_pkg::ST_RUN && !o_ext_pin_irq_mask || rst_evt)
    else $error("no wake from wait");
endmodule : lpm_ctrl

// ### hw/lpm_pkg.sv
// package of constants and carrier types for the low-power mode controller
// Overview of operation
// - in wait the processor clock stops while the bus clock keeps running.
// - stop halts the processor clock, and the bus clock when keep-alive is 0.
// - converter runs in wait; its enabled requests wake from wait.
// - converter goes inactive on stop, aborts conversion, resumes after interrupt exit.
// - breakpoint unit active in wait, inactive in stop, registers untouched.
// - wait clears the interrupt mask; interrupt wake keeps it clear, reset sets it.
// - stop clears the interrupt mask; interrupt wake keeps it clear, reset sets it.
// - after stop the processor clock restarts only after the stabilization delay.
// - clock generator stays active in wait; software may deselect or power off the PLL.
// - keep-alive clear: stop disables oscillator and PLL, generator outputs held low.
// - keep-alive set: stop shuts only the PLL, oscillator keeps running.
// - watchdog runs in wait and resets the device on timeout when enabled.
// - stop removes the watchdog clock and clears the integration counter.
// - stop instruction acts only while the stop-enable bit is set.
// - external pin interrupt wakes wait and stop when its mask is clear.
// - keypad interrupt wakes wait and stop when its mask is clear.
// - enabled voltage monitor stays active, in stop only with its stop bit set; its reset ends wait or stop.
// - serial unit active in wait, wakes it; in stop inactive, frame invalid.
// - SPI active in wait, wakes it; in stop kept; reset exit resets it.
// - timers active in wait, wake it; halted with state kept during stop.
// - timebase runs in wait; its register is not reachable in wait or stop.
// - timebase active in stop only with keep-alive set, for periodic wake.
// - stop exit holds clocks off 4096 crystal cycles via a 13-bit counter.
// - short recovery bit cuts the stop recovery delay to 32 crystal cycles.
package lpm_pkg;
  // register offsets
  localparam logic [2:0] CFG_ONE_OFS = 3'h0;
  localparam logic [2:0] CFG_TWO_OFS = 3'h1;
  localparam logic [2:0] PLL_CTL_OFS = 3'h2;
  localparam logic [2:0] STATUS_OFS = 3'h3;
  // config_reg_one fields
  localparam int STOP_EN_BIT = 0;
  localparam int SHORT_REC_BIT = 1;
  localparam int LVI_PWR_BIT = 2;
  localparam int LVI_RST_BIT = 3;
  localparam int LVI_STOP_BIT = 4;
  localparam int WDOG_EN_BIT = 5;
  // config_reg_two and pll_control_reg fields
  localparam int KEEP_ALIVE_BIT = 0;
  localparam int PLL_PWR_BIT = 0;
  localparam int BASE_SEL_BIT = 1;
  // reset values
  localparam logic [7:0] CFG_ONE_RST = 8'h2C;
  localparam logic [7:0] CFG_TWO_RST = 8'h00;
  localparam logic [7:0] PLL_CTL_RST = 8'h01;
  // recovery lengths in crystal-clock cycles
  localparam int RECOV_FULL = 4096;
  localparam int RECOV_SHORT = 32;
  localparam int RECOV_W = 12;
  // operating states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_STOP = 2'b10,
    ST_RECOVER = 2'b11
  } lpm_state_t;
  // wake requests, already enabled inside each source unit except ext_irq and key_irq, which the controller masks
  typedef struct packed {
    logic ext_irq;
    logic key_irq;
    logic tbm_irq;
    logic adc_irq;
    logic sci_irq;
    logic spi_irq;
    logic tim_irq;
    logic cgm_irq;
  } lpm_wake_t;
  // clock gates
  typedef struct packed {
    logic cpu;
    logic bus;
    logic osc;
    logic pll;
    logic pll_sel;
    logic xtal_out;
    logic gen_out;
    logic gen_irq;
    logic wdog;
  } lpm_clk_t;
  // unit controls
  typedef struct packed {
    logic adc_act;
    logic adc_abort;
    logic brk_act;
    logic sci_act;
    logic sci_frame_bad;
    logic spi_act;
    logic spi_reset;
    logic tim_act;
    logic tbm_act;
    logic tbm_access;
    logic lvi_act;
    logic sim_clr;
  } lpm_unit_t;
endpackage : lpm_pkg

// ### hw/lpm_recovery.sv
// stop recovery counter that holds clocks off for a number of crystal ticks
`timescale 1ns/100ps
module lpm_recovery #(
  parameter int FULL = lpm_pkg::RECOV_FULL,
  parameter int SHORT = lpm_pkg::RECOV_SHORT,
  parameter int W = lpm_pkg::RECOV_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // control
  input wire logic i_start,
  input wire logic i_short,
  input wire logic i_tick,
  // result
  output logic o_done
);
  logic [W:0] cnt_q;
  logic busy_q;

  // count crystal ticks down from the chosen length
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cnt_q <= i_short ? (W+1)'(SHORT) : (W+1)'(FULL);
        busy_q <= 1'b1;
      end else if (busy_q && i_tick) begin
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == (W+1)'(1)) begin
          busy_q <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end
endmodule : lpm_recovery

// ### verif/low_power_mode_control_tb.sv
// self-checking bench for the low-power mode controller
`timescale 1ns/100ps
module low_power_mode_control_tb;
  logic i_clk, i_reset_n, i_we, i_re, i_wait_exec, i_stop_exec, ext_mask, i_ext_rst;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, wv, dly;
  logic o_ext_pin_irq_mask, rd_pend, entry_seen, spi_rst_seen;
  logic key_mask, lvi_trip, wdog_to, o_reset_req, rst_req_seen;
  lpm_pkg::lpm_wake_t req, wake;
  lpm_pkg::lpm_clk_t o_clk;
  lpm_pkg::lpm_unit_t o_unit;
  lpm_pkg::lpm_state_t o_state;
  logic [7:0] exp_q[$];
  integer bad_count, check_count, seed;
  // design with shortened recovery: short 32*2, full 64*2 clocks
  lpm_ctrl #(.XTAL_DIV(2), .RECOV_FULL(64), .RECOV_SHORT(32)) uut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .i_wait_exec(i_wait_exec),
    .i_stop_exec(i_stop_exec), .i_ext_pin_irq_mask_load(1'b0), .i_ext_pin_irq_mask_val(1'b0),
    .o_ext_pin_irq_mask(o_ext_pin_irq_mask), .i_wake(wake), .i_ext_pin_irq_mask(ext_mask),
    .i_keypad_irq_mask(key_mask), .i_ext_rst(i_ext_rst), .i_lvi_trip(lvi_trip),
    .i_wdog_timeout(wdog_to), .o_clk(o_clk), .o_unit(o_unit), .o_reset_req(o_reset_req),
    .o_state(o_state));
  lpm_wake_model pm (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req),
    .i_delay(dly), .i_state(o_state), .o_wake(wake));
  // clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_we <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge i_clk);
    i_re <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_re <= 1'b0;
  endtask : rd
  task automatic pulse(input logic stop);
    @(posedge i_clk);
    if (stop) i_stop_exec <= 1'b1;
    else i_wait_exec <= 1'b1;
    @(posedge i_clk);
    i_stop_exec <= 1'b0;
    i_wait_exec <= 1'b0;
  endtask : pulse
  task automatic wait_st(input lpm_pkg::lpm_state_t s, input integer n);
    integer k;
    k = 0;
    @(negedge i_clk);
    while (o_state !== s && k < n) begin
      @(negedge i_clk);
      k++;
    end
  endtask : wait_st
  // read data monitor: oldest note against the cycle after each read strobe
  always @(posedge i_clk) rd_pend <= i_re;
  always @(negedge i_clk) begin
    if (rd_pend === 1'b1) check("rdata", 16'(o_rdata), 16'(exp_q.pop_front()));
  end
  // catch one-cycle pulses
  always @(posedge i_clk) begin
    if (o_unit.adc_abort === 1'b1 && o_unit.sim_clr === 1'b1 && o_unit.sci_frame_bad === 1'b1)
      entry_seen <= 1'b1;
    if (o_unit.spi_reset === 1'b1) spi_rst_seen <= 1'b1;
    if (o_reset_req === 1'b1) rst_req_seen <= 1'b1;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    seed = 32'h3ae1;
    bad_count = 0;
    check_count = 0;
    {i_reset_n, i_we, i_re, i_wait_exec, i_stop_exec, ext_mask, i_ext_rst} = '0;
    {i_addr, i_wdata, dly, entry_seen, spi_rst_seen} = '0;
    {key_mask, lvi_trip, wdog_to, rst_req_seen} = '0;
    req = '0;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    // reset values, masked write, unmapped place
    rd(lpm_pkg::CFG_ONE_OFS, lpm_pkg::CFG_ONE_RST);
    rd(lpm_pkg::CFG_TWO_OFS, lpm_pkg::CFG_TWO_RST);
    rd(lpm_pkg::PLL_CTL_OFS, lpm_pkg::PLL_CTL_RST);
    wv = 8'($random(seed));
    wr(3'h6, wv);
    rd(3'h6, 8'h00);
    wr(lpm_pkg::CFG_ONE_OFS, wv);
    rd(lpm_pkg::CFG_ONE_OFS, wv & 8'h3F);
    // wait with the PLL deselected and off, timer wake after a random delay
    wr(lpm_pkg::CFG_ONE_OFS, 8'h2E);
    wr(lpm_pkg::PLL_CTL_OFS, 8'h00);
    dly <= 8'($random(seed)) & 8'h0F;
    req.tim_irq <= 1'b1;
    pulse(1'b0);
    wait_st(lpm_pkg::ST_WAIT, 4);
    check("wait st", 16'(o_state), 16'(lpm_pkg::ST_WAIT));
    check("wait clk", 16'({o_clk.cpu, o_clk.bus, o_clk.gen_out, o_clk.pll, o_clk.pll_sel}),
      16'h000C);
    check("wait wdog", 16'({o_clk.wdog, o_unit.lvi_act, o_unit.brk_act}), 16'h0007);
    check("wait units", 16'({o_unit.adc_act, o_unit.sci_act, o_unit.spi_act, o_unit.tim_act,
      o_unit.tbm_act, o_unit.tbm_access}), 16'h003E);
    check("wait ext_pin_irq_mask", 16'(o_ext_pin_irq_mask), 16'h0000);
    wait_st(lpm_pkg::ST_RUN, 40);
    check("wake run", 16'(o_state), 16'(lpm_pkg::ST_RUN));
    check("wake ext_pin_irq_mask", 16'(o_ext_pin_irq_mask), 16'h0000);
    req <= '0;
    // stop while the stop enable is clear is ignored
    pulse(1'b1);
    repeat (5) @(posedge i_clk);
    check("stop off", 16'({o_state, o_clk.wdog}), 16'h0001);
    // stop, masked pin first, then short recovery
    wr(lpm_pkg::CFG_ONE_OFS, 8'h2F);
    wr(lpm_pkg::PLL_CTL_OFS, lpm_pkg::PLL_CTL_RST);
    ext_mask <= 1'b1;
    req.ext_irq <= 1'b1;
    pulse(1'b1);
    wait_st(lpm_pkg::ST_STOP, 4);
    check("stop clk", 16'({o_clk.cpu, o_clk.bus, o_clk.osc, o_clk.pll, o_clk.xtal_out,
      o_clk.gen_out, o_clk.gen_irq, o_clk.wdog}), 16'h0000);
    check("stop units", 16'({o_unit.adc_act, o_unit.brk_act, o_unit.sci_act, o_unit.spi_act,
      o_unit.tim_act, o_unit.tbm_act, o_unit.tbm_access}), 16'h0000);
    check("stop ext_pin_irq_mask", 16'(o_ext_pin_irq_mask), 16'h0000);
    repeat (30) @(posedge i_clk);
    check("masked", 16'({o_state, entry_seen}), 16'h0005);
    ext_mask <= 1'b0;
    wait_st(lpm_pkg::ST_RECOVER, 10);
    repeat (50) @(negedge i_clk);
    check("short hold", 16'({o_state, o_clk.cpu}), 16'h0006);
    wait_st(lpm_pkg::ST_RUN, 30);
    check("short run", 16'({o_state, o_clk.cpu, o_ext_pin_irq_mask}), 16'h0002);
    req <= '0;
    // keep-alive stop, timebase wake, full recovery
    wr(lpm_pkg::CFG_TWO_OFS, 8'h01);
    wr(lpm_pkg::CFG_ONE_OFS, 8'h2D);
    req.tbm_irq <= 1'b1;
    pulse(1'b1);
    wait_st(lpm_pkg::ST_STOP, 4);
    check("keep clk", 16'({o_clk.cpu, o_clk.bus, o_clk.osc, o_clk.pll, o_clk.xtal_out,
      o_unit.tbm_act}), 16'h001B);
    wait_st(lpm_pkg::ST_RECOVER, 40);
    repeat (110) @(negedge i_clk);
    check("full hold", 16'(o_state), 16'(lpm_pkg::ST_RECOVER));
    wait_st(lpm_pkg::ST_RUN, 40);
    check("full run", 16'({o_state, o_clk.cpu}), 16'h0001);
    req <= '0;
    // stop left through the reset pin
    pulse(1'b1);
    wait_st(lpm_pkg::ST_STOP, 4);
    i_ext_rst <= 1'b1;
    @(posedge i_clk);
    i_ext_rst <= 1'b0;
    wait_st(lpm_pkg::ST_RUN, 200);
    check("rst exit", 16'({o_state, o_ext_pin_irq_mask, spi_rst_seen}), 16'h0003);
    // keypad masked in wait, supply monitor reset ends the wait
    key_mask <= 1'b1;
    req.key_irq <= 1'b1;
    pulse(1'b0);
    repeat (20) @(posedge i_clk);
    check("key masked", 16'(o_state), 16'(lpm_pkg::ST_WAIT));
    lvi_trip <= 1'b1;
    @(posedge i_clk);
    lvi_trip <= 1'b0;
    wait_st(lpm_pkg::ST_RUN, 4);
    repeat (2) @(negedge i_clk);
    check("lvi exit", 16'({o_state, o_ext_pin_irq_mask, rst_req_seen}), 16'h0003);
    req <= '0;
    rst_req_seen <= 1'b0;
    // enabled watchdog timeout in run asks for a reset
    @(posedge i_clk);
    wdog_to <= 1'b1;
    @(posedge i_clk);
    wdog_to <= 1'b0;
    repeat (3) @(negedge i_clk);
    check("wdog rst", 16'({o_state, o_ext_pin_irq_mask, rst_req_seen}), 16'h0003);
    end_of_test();
  end
endmodule : low_power_mode_control_tb

// ### verif/lpm_wake_model.sv
// wake-source model standing for the peripheral units and interrupt pins
`timescale 1ns/100ps
module lpm_wake_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // request from the bench and controller state
  input wire lpm_pkg::lpm_wake_t i_req,
  input wire logic [7:0] i_delay,
  input wire lpm_pkg::lpm_state_t i_state,
  // wake lines into the controller
  output lpm_pkg::lpm_wake_t o_wake
);
  logic [7:0] cnt_q;
  // raise the asked lines after a chosen delay in wait or stop, drop them back in run
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wake <= '0;
      cnt_q <= 8'h00;
    end else if (i_req == '0 || i_state == lpm_pkg::ST_RUN) begin
      o_wake <= '0;
      cnt_q <= 8'h00;
    end else if (cnt_q < i_delay) begin
      cnt_q <= cnt_q + 8'h01;
    end else begin
      o_wake <= i_req;
    end
  end
endmodule : lpm_wake_model
